// ===== sram_defs.svh
// constants for the single-port ram block: register map, field positions, limits
// assumes inclusion by bare name from every file that needs them
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH

// -----------------------------------------------------------------------------
// register map (byte addresses on the ahb-lite slave)
// -----------------------------------------------------------------------------
`define SRAM_OFS_W          12
`define SRAM_CTRL_OFS       12'h000
`define SRAM_WCNT_OFS       12'h004
`define SRAM_LADDR_OFS      12'h008

// -----------------------------------------------------------------------------
// fields and reset values
// -----------------------------------------------------------------------------
`define SRAM_CTRL_INHIBIT   0
`define SRAM_CTRL_RST       1'b0
`define SRAM_WCNT_W         16
`define SRAM_WCNT_RST       16'h0000
`define SRAM_WCNT_INC       16'h0001
`define SRAM_LADDR_W        16
`define SRAM_LADDR_RST      16'h0000
`define SRAM_RDATA_RST      32'h0000_0000
`define SRAM_HRESP_OKAY     1'b0
`define SRAM_HREADY_ON      1'b1

// -----------------------------------------------------------------------------
// physical block depth limits in words
// -----------------------------------------------------------------------------
`define SRAM_BLK_AUTO       0
`define SRAM_BLK_MIN        32
`define SRAM_BLK_MAX        65536

`endif

// ===== sram_pkg.sv
// types shared by the single-port ram block
// assumes sram_defs.svh is on the include path
`include "sram_defs.svh"

package sram_pkg;

  // ---------------------------------------------------------------------------
  // configuration choices
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CLK_SINGLE = 2'h1,
    CLK_DUAL   = 2'h2
  } clock_mode_type;

  typedef enum logic [1:0] {
    RDW_NEW_DATA  = 2'h1,
    RDW_DONT_CARE = 2'h2
  } rdw_type;

  // ---------------------------------------------------------------------------
  // state of the register slave
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic                        inhibit;
    logic [`SRAM_WCNT_W-1:0]     wcount;
    logic [`SRAM_LADDR_W-1:0]    last_addr;
    logic                        ph_sel;
    logic                        ph_write;
    logic [`SRAM_OFS_W-1:0]      ph_ofs;
    logic [31:0]                 rdata;
  } ahb_state_type;

endpackage

// ===== port_reg.sv
// optional port register: captures d on enabled edges, or passes d through
// assumes rst_n already combines system reset and any asynchronous clear
`timescale 1ns/1ps
`default_nettype none

module port_reg #(
  parameter int W   = 8,
  parameter bit REG = 1'b1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] val;
  } port_state_type;

  port_state_type s_q;
  port_state_type s_d;

  always_comb
  begin
    s_d = s_q;
    if (en)
    begin
      s_d.val = d;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // bypassed ports cost no flops at all
  assign q = REG ? s_q.val : d;

endmodule // port_reg

`default_nettype wire

// ===== sram_ahb_regs.sv
// ahb-lite slave holding the write inhibit control and write statistics
// assumes a single master, single word transfers, and wr_event on hclk
`timescale 1ns/1ps
`default_nettype none

module sram_ahb_regs
  import sram_pkg::*;
(
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic      [31:0]              hrdata,
  input  wire logic                     wr_event,
  input  wire logic [`SRAM_LADDR_W-1:0] wr_addr,
  output logic                          inhibit
);

  ahb_state_type s_q;
  ahb_state_type s_d;
  logic          take;
  logic [`SRAM_OFS_W-1:0] ofs;

  // only whole words exist, so hsize and the low address bits are ignored
  assign take = hsel & hready & htrans[1];
  assign ofs  = {haddr[`SRAM_OFS_W-1:2], 2'h0};

  always_comb
  begin
    s_d = s_q;
    // -------------------------------------------------------------------------
    // data phase of a write
    // -------------------------------------------------------------------------
    if (s_q.ph_sel && s_q.ph_write)
    begin
      case (s_q.ph_ofs)
        `SRAM_CTRL_OFS: s_d.inhibit = hwdata[`SRAM_CTRL_INHIBIT];
        `SRAM_WCNT_OFS: s_d.wcount  = `SRAM_WCNT_RST;
        default:        s_d.inhibit = s_d.inhibit;
      endcase
    end
    // a store landing with the clear still counts
    if (wr_event)
    begin
      s_d.wcount    = s_d.wcount + `SRAM_WCNT_INC;
      s_d.last_addr = wr_addr;
    end
    // -------------------------------------------------------------------------
    // address phase; read data built from next state so a write just ahead
    // is visible to a read right behind it
    // -------------------------------------------------------------------------
    s_d.ph_sel   = take;
    s_d.ph_write = hwrite;
    s_d.ph_ofs   = ofs;
    s_d.rdata    = `SRAM_RDATA_RST;
    if (take && !hwrite)
    begin
      case (ofs)
        `SRAM_CTRL_OFS:  s_d.rdata = {31'h0000_0000, s_d.inhibit};
        `SRAM_WCNT_OFS:  s_d.rdata = {16'h0000, s_d.wcount};
        `SRAM_LADDR_OFS: s_d.rdata = {16'h0000, s_d.last_addr};
        default:         s_d.rdata = `SRAM_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q.inhibit   <= `SRAM_CTRL_RST;
      s_q.wcount    <= `SRAM_WCNT_RST;
      s_q.last_addr <= `SRAM_LADDR_RST;
      s_q.ph_sel    <= 1'b0;
      s_q.ph_write  <= 1'b0;
      s_q.ph_ofs    <= '0;
      s_q.rdata     <= `SRAM_RDATA_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign hreadyout = `SRAM_HREADY_ON;
  assign hresp     = `SRAM_HRESP_OKAY;
  assign hrdata    = s_q.rdata;
  assign inhibit   = s_q.inhibit;

endmodule // sram_ahb_regs

`default_nettype wire

// ===== sram_top.sv
// single-port synchronous ram with selectable port registers and clocking
// assumes user logic sits on hclk (input side) and, in dual mode, on out_clk
//
// Operation
// - single clock drives all registers, one enable
// - dual mode: input clock drives input registers
// - dual mode: read data register on output clock
// - data/wren, address, q each optionally registered
// - per-clock enables hold registers when deasserted
// - input registers optionally ignore clock enable
// - output registers optionally ignore clock enable
// - block depth auto or power of two
// - width and word count parameters, address derived
// - new-data read during write returns new word
// - optional clear resets port registers, q optional
// - active-low address stall holds address register
`timescale 1ns/1ps
`default_nettype none

module sram_top
  import sram_pkg::*;
#(
  parameter int             DATA_W          = 32,
  parameter int             WORDS           = 1024,
  parameter int             ADDR_W          = $clog2(WORDS),
  parameter int             BYTE_W          = 8,
  parameter int             MAX_BLOCK_DEPTH = `SRAM_BLK_AUTO,
  parameter clock_mode_type CLOCK_MODE      = CLK_SINGLE,
  parameter rdw_type        RDW             = RDW_NEW_DATA,
  parameter bit             REG_DATA_WREN   = 1'b1,
  parameter bit             REG_ADDR        = 1'b1,
  parameter bit             REG_Q           = 1'b1,
  parameter bit             PER_CLOCK_EN    = 1'b0,
  parameter bit             USE_IN_CLKEN    = 1'b1,
  parameter bit             USE_OUT_CLKEN   = 1'b1,
  parameter bit             USE_ACLR        = 1'b0,
  parameter bit             ACLR_Q          = 1'b0,
  parameter bit             USE_RDEN        = 1'b1,
  parameter bit             USE_BYTE_EN     = 1'b0,
  parameter bit             USE_ADDR_STALL  = 1'b0
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     out_clk,
  input  wire logic                     in_clken,
  input  wire logic                     out_clken,
  input  wire logic                     aclr,
  input  wire logic                     addr_stall_n,
  input  wire logic [DATA_W-1:0]        wdata,
  input  wire logic                     wren,
  input  wire logic [DATA_W/BYTE_W-1:0] byte_en,
  input  wire logic [ADDR_W-1:0]        addr,
  input  wire logic                     rden,
  output logic      [DATA_W-1:0]        q,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic      [31:0]              hrdata
);

  // ---------------------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------------------
  localparam int BYTES = DATA_W / BYTE_W;
  localparam int SPAN  = 2 ** ADDR_W;

  // latency at q in hclk edges, counted from the edge that drives addr:
  //   address and q both registered    two edges
  //   either one bypassed              one edge
  //   both bypassed                    combinational, same cycle
  // the write strobe rides with the data option, not the address option:
  // bypassed data with a registered address stores to the previous address,
  // so mixed settings suit only users who pipeline addr themselves
  // rden follows the address option so a strobe meets its address, except while addr_stall_n holds the address register
  // dual mode reads the array combinationally and samples it on out_clk;
  // addr must settle before an out_clk edge, nothing here resynchronises it
  // byte lanes off means every lane is written; byte_en is then ignored
  // the depth limit snaps up to a power of two and never splits below one
  // block, so odd word counts leave the top block partly empty

  // requested limit snapped to a power of two inside the legal range
  function automatic int blk_depth_f();
    int lim;
    lim = MAX_BLOCK_DEPTH;
    if (lim == `SRAM_BLK_AUTO || lim >= SPAN)
    begin
      return SPAN;
    end
    if (lim < `SRAM_BLK_MIN)
    begin
      lim = `SRAM_BLK_MIN;
    end
    if (lim > `SRAM_BLK_MAX)
    begin
      lim = `SRAM_BLK_MAX;
    end
    lim = 2 ** $clog2(lim);
    return (lim > SPAN) ? SPAN : lim;
  endfunction

  localparam int BLK_DEPTH = blk_depth_f();
  localparam int NUM_BLK   = (WORDS + BLK_DEPTH - 1) / BLK_DEPTH;
  localparam int BLK_AW    = (BLK_DEPTH > 1) ? $clog2(BLK_DEPTH) : 1;
  localparam int BLK_IW    = (NUM_BLK > 1) ? $clog2(NUM_BLK) : 1;
  localparam int IN_W      = DATA_W + BYTES + 1;

  typedef struct packed {
    logic [DATA_W-1:0] q;
  } out_state_type;

  // ---------------------------------------------------------------------------
  // clocks, enables and clears
  // ---------------------------------------------------------------------------
  logic              rd_clk;
  logic              in_en;
  logic              out_en_src;
  logic              out_en;
  logic              addr_en;
  logic              clr_n;
  logic              q_clr_n;

  // dual mode moves only the read data register onto out_clk
  assign rd_clk = (CLOCK_MODE == CLK_DUAL) ? out_clk : hclk;
  assign in_en  = USE_IN_CLKEN ? in_clken : 1'b1;
  assign out_en_src = (PER_CLOCK_EN && CLOCK_MODE == CLK_DUAL) ?
                      out_clken : in_clken;
  assign out_en  = USE_OUT_CLKEN ? out_en_src : 1'b1;
  assign addr_en = in_en & (~USE_ADDR_STALL | addr_stall_n);
  // the clear is asynchronous on purpose; it must not glitch
  assign clr_n   = hresetn & ~(USE_ACLR & aclr);
  assign q_clr_n = hresetn & ~(USE_ACLR & ACLR_Q & aclr);

  // ---------------------------------------------------------------------------
  // input side port registers, all on hclk
  // ---------------------------------------------------------------------------
  logic [IN_W-1:0]   in_raw;
  logic [IN_W-1:0]   in_reg;
  logic [DATA_W-1:0] w_data;
  logic [BYTES-1:0]  w_be;
  logic              w_wren;
  logic [ADDR_W-1:0] w_addr;
  logic              w_rden;

  assign in_raw = {wren, (USE_BYTE_EN ? byte_en : {BYTES{1'b1}}), wdata};

  port_reg #(
    .W   (IN_W),
    .REG (REG_DATA_WREN)
  ) u_data_reg (
    .clk   (hclk),
    .rst_n (clr_n),
    .en    (in_en),
    .d     (in_raw),
    .q     (in_reg)
  );

  port_reg #(
    .W   (ADDR_W),
    .REG (REG_ADDR)
  ) u_addr_reg (
    .clk   (hclk),
    .rst_n (clr_n),
    .en    (addr_en),
    .d     (addr),
    .q     (w_addr)
  );

  port_reg #(
    .W   (1),
    .REG (REG_ADDR)
  ) u_rden_reg (
    .clk   (hclk),
    .rst_n (clr_n),
    .en    (in_en),
    .d     (USE_RDEN ? rden : 1'b1),
    .q     (w_rden)
  );

  assign w_data = in_reg[DATA_W-1:0];
  assign w_be   = in_reg[DATA_W+BYTES-1:DATA_W];
  assign w_wren = in_reg[IN_W-1];

  // ---------------------------------------------------------------------------
  // register slave: write inhibit and store statistics
  // ---------------------------------------------------------------------------
  logic              inhibit;
  logic              wr_go;

  // the array takes the post-option signals on each enabled hclk edge
  assign wr_go = w_wren & in_en & ~inhibit;

  sram_ahb_regs u_regs (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_event  (wr_go),
    .wr_addr   (`SRAM_LADDR_W'(w_addr)),
    .inhibit   (inhibit)
  );

  // ---------------------------------------------------------------------------
  // storage: one array per physical block
  // ---------------------------------------------------------------------------
  logic [BLK_IW-1:0] blk_idx;
  logic [BLK_AW-1:0] blk_ofs;
  logic [DATA_W-1:0] blk_rd [NUM_BLK];
  logic [DATA_W-1:0] read_word;
  logic [DATA_W-1:0] merged;
  logic [DATA_W-1:0] rd_word;

  assign blk_idx = BLK_IW'(w_addr >> BLK_AW);
  assign blk_ofs = BLK_AW'(w_addr);

  for (genvar b = 0; b < NUM_BLK; b++)
  begin : g_blk
    logic [DATA_W-1:0] mem [BLK_DEPTH];

    always_ff @(posedge hclk)
    begin
      if (wr_go && blk_idx == BLK_IW'(b))
      begin
        for (int k = 0; k < BYTES; k++)
        begin
          if (w_be[k])
          begin
            mem[blk_ofs][k*BYTE_W +: BYTE_W] <= w_data[k*BYTE_W +: BYTE_W];
          end
        end
      end
    end

    assign blk_rd[b] = mem[blk_ofs];
  end

  // out-of-range block indices read as zero rather than wrap
  assign read_word = (int'(blk_idx) < NUM_BLK) ? blk_rd[blk_idx] : '0;

  // masked byte lanes keep the old contents on the forwarded word
  for (genvar k = 0; k < BYTES; k++)
  begin : g_merge
    assign merged[k*BYTE_W +: BYTE_W] = w_be[k] ? w_data[k*BYTE_W +: BYTE_W] :
                                                  read_word[k*BYTE_W +: BYTE_W];
  end

  // forwarding costs a mux on the read path but hides the write latency
  assign rd_word = (RDW == RDW_NEW_DATA && wr_go) ? merged : read_word;

  // ---------------------------------------------------------------------------
  // read data register
  // ---------------------------------------------------------------------------
  // with the don't-care option a same-address read returns the old word;
  // the model stays deterministic instead of showing unknowns
  // a clear pulse empties q only when ACLR_Q is set; otherwise q keeps its
  // word and the next enabled read refreshes it
  // q leaves reset asynchronously on rd_clk's domain: in dual mode release
  // hresetn away from an out_clk edge
  out_state_type o_q;
  out_state_type o_d;

  always_comb
  begin
    o_d = o_q;
    if (out_en && w_rden)
    begin
      o_d.q = rd_word;
    end
  end

  always_ff @(posedge rd_clk or negedge q_clr_n)
  begin
    if (!q_clr_n)
    begin
      o_q <= '0;
    end
    else
    begin
      o_q <= o_d;
    end
  end

  // unregistered q follows the array directly and ignores the strobe
  assign q = REG_Q ? o_q.q : rd_word;

endmodule // sram_top

`default_nettype wire

// ===== sram_top_chk.sv
// port checker for sram_top, single clock, ports registered, masked stores unread
// assumes bind below; inhibit is mirrored from ahb writes to offset zero
`timescale 1ns/1ps
`default_nettype none

module sram_top_chk #(
  parameter int DATA_W = 32
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              in_clken,
  input wire logic              aclr,
  input wire logic              addr_stall_n,
  input wire logic              wren,
  input wire logic              rden,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] q,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata
);
  logic ph_w;
  logic inh;

  // ---------------------------------------------------------------------------
  // inhibit mirror, needed because an inhibited store leaves old data readable
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ph_w <= 1'b0;
      inh  <= 1'b0;
    end
    else
    begin
      ph_w <= hsel && hready && htrans[1] && hwrite && haddr[11:2] == 10'h000;
      if (ph_w)
        inh <= hwdata[0];
    end

  default clocking cb @(posedge hclk); endclocking

  chk_clken_hold: assert property (disable iff (!hresetn || aclr)
    !in_clken |=> $stable(q)) else $error("q moved with clock enable low");
  chk_rden_hold: assert property (disable iff (!hresetn || aclr)
    in_clken && !rden |-> ##2 $stable(q)) else $error("q moved without read strobe");
  chk_rdw_new: assert property (disable iff (!hresetn || aclr)
    wren && rden && in_clken && addr_stall_n ##1 in_clken && !inh |=> q == $past(wdata, 2))
    else $error("read during write missed new word");
  chk_aclr_clear: assert property (disable iff (!hresetn)
    aclr |-> q == '0) else $error("q not cleared by clear");
  chk_reset_clear: assert property (disable iff (!hresetn)
    $rose(hresetn) |-> q == '0 && hrdata == 32'h0) else $error("outputs not zero after reset");
  chk_ready_high: assert property (disable iff (!hresetn)
    hreadyout == 1'b1) else $error("wait state inserted");
  chk_resp_okay: assert property (disable iff (!hresetn)
    hresp == 1'b0) else $error("error response given");
  chk_rdata_idle: assert property (disable iff (!hresetn)
    !(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
    else $error("read data outside read data phase");

  cover property (disable iff (!hresetn) wren && rden && in_clken);
  cover property (disable iff (!hresetn) aclr);
  cover property (disable iff (!hresetn) !addr_stall_n && rden);
  cover property (disable iff (!hresetn) hsel && htrans[1] && !hwrite);
endmodule // sram_top_chk

bind sram_top sram_top_chk #(.DATA_W(DATA_W)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .in_clken(in_clken), .aclr(aclr),
  .addr_stall_n(addr_stall_n), .wren(wren), .rden(rden), .wdata(wdata), .q(q),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
);

`default_nettype wire

// ===== user_port.sv
// user logic model on the memory port, issues reads and writes
// assumes registered address and q: a read answers two edges after issue
`timescale 1ns/1ps
`default_nettype none

module user_port #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 6
) (
  input  wire logic              hclk,
  input  wire logic [DATA_W-1:0] q,
  output logic      [DATA_W-1:0] wdata,
  output logic                   wren,
  output logic      [ADDR_W-1:0] addr,
  output logic                   rden
);
  initial
  begin
    wdata = '0;
    wren = 1'b0;
    addr = '0;
    rden = 1'b0;
  end

  task automatic put(input logic w, input logic r, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    @(posedge hclk);
    wren  <= w;
    rden  <= r;
    addr  <= a;
    wdata <= d;
  endtask

  // released data toggles so a stale word never passes for a live one
  task automatic idle();
    @(posedge hclk);
    wren  <= 1'b0;
    rden  <= 1'b0;
    wdata <= ~wdata;
  endtask

  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] r);
    put(w, 1'b1, a, d);
    idle();
    @(posedge hclk);
    #1;
    r = q;
  endtask
endmodule // user_port

`default_nettype wire

// ===== testbench.sv
// self-checking bench for sram_top, single clock, clear and stall enabled
// assumes user_port on the memory port and an ahb-lite master in tasks here
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int          AW   = 6;
  localparam logic [31:0] BASE = 32'hA500_0000;

  logic          hclk, hresetn, in_clken, aclr, addr_stall_n, wren, rden;
  logic [31:0]   wdata, q, haddr, hwdata, hrdata, rd;
  logic [AW-1:0] addr;
  logic [3:0]    be;
  logic          hsel, hwrite, hready, hresp;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  int            error_cnt, check_count;

  sram_top #(.WORDS(64), .USE_ACLR(1'b1), .ACLR_Q(1'b1), .USE_ADDR_STALL(1'b1),
    .USE_BYTE_EN(1'b1)) u_sram_top (
    .hclk(hclk), .hresetn(hresetn), .out_clk(hclk), .in_clken(in_clken), .out_clken(in_clken),
    .aclr(aclr), .addr_stall_n(addr_stall_n), .wdata(wdata), .wren(wren), .byte_en(be),
    .addr(addr), .rden(rden), .q(q), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata));

  user_port #(.ADDR_W(AW)) u_user_port (.hclk(hclk), .q(q), .wdata(wdata), .wren(wren),
    .addr(addr), .rden(rden));

  always #2 hclk = ~hclk;

  // ---------------------------------------------------------------------------
  // checking, bus tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        error_cnt++;
        report_and_stop();
      end
      @(posedge hclk);
    end
  endtask

  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {20'h0_0000, a};
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask

  task automatic rreg(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    in_clken = 1'b1;
    aclr = 1'b0;
    addr_stall_n = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    be = 4'hF;
    error_cnt = 0;
    check_count = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    check(q, 32'h0);
    rreg(12'h000, 32'h0);
    rreg(12'h004, 32'h0);
    rreg(12'h008, 32'h0);
    for (int i = 0; i < 4; i++)
      u_user_port.put(1'b1, 1'b0, i[AW-1:0], BASE + 32'(i));
    u_user_port.idle();
    for (int i = 0; i < 4; i++)
    begin
      u_user_port.acc(1'b0, i[AW-1:0], 32'h0, rd);
      check(rd, BASE + 32'(i));
    end
    rreg(12'h004, 32'h4);
    rreg(12'h008, 32'h3);
    u_user_port.acc(1'b1, 6'h08, 32'h0BAD_F00D, rd);
    check(rd, 32'h0BAD_F00D);
    // store refused while inhibited, count untouched
    ahb(1'b1, 12'h000, 32'h1, rd);
    u_user_port.put(1'b1, 1'b0, 6'h01, 32'h1111_2222);
    u_user_port.idle();
    u_user_port.acc(1'b0, 6'h01, 32'h0, rd);
    check(rd, BASE + 32'h1);
    rreg(12'h004, 32'h5);
    ahb(1'b1, 12'h000, 32'h0, rd);
    ahb(1'b1, 12'h004, 32'h0, rd);
    rreg(12'h004, 32'h0);
    rreg(12'h008, 32'h8);
    rreg(12'h00C, 32'h0);
    // enable low: write and read both ignored, q held
    @(posedge hclk);
    in_clken <= 1'b0;
    u_user_port.put(1'b1, 1'b1, 6'h02, 32'hDEAD_0002);
    u_user_port.idle();
    repeat (2) @(posedge hclk);
    #1;
    check(q, BASE + 32'h1);
    @(posedge hclk);
    in_clken <= 1'b1;
    u_user_port.acc(1'b0, 6'h02, 32'h0, rd);
    check(rd, BASE + 32'h2);
    u_user_port.put(1'b0, 1'b0, 6'h03, 32'h0);
    u_user_port.idle();
    repeat (2) @(posedge hclk);
    #1;
    check(q, BASE + 32'h2);
    @(posedge hclk);
    addr_stall_n <= 1'b0;
    u_user_port.acc(1'b0, 6'h00, 32'h0, rd);
    check(rd, BASE + 32'h3);
    @(posedge hclk);
    addr_stall_n <= 1'b1;
    aclr <= 1'b1;
    @(posedge hclk);
    #1;
    check(q, 32'h0);
    @(posedge hclk);
    aclr <= 1'b0;
    u_user_port.acc(1'b0, 6'h00, 32'h0, rd);
    check(rd, BASE);
    // low two lanes only; the upper half keeps the earlier word
    @(posedge hclk);
    be <= 4'h3;
    u_user_port.put(1'b1, 1'b0, 6'h02, 32'h1234_5678);
    u_user_port.idle();
    be <= 4'hF;
    u_user_port.acc(1'b0, 6'h02, 32'h0, rd);
    check(rd, 32'hA500_5678);
    // second reset: last address cleared, contents kept
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    check(q, 32'h0);
    rreg(12'h008, 32'h0);
    u_user_port.acc(1'b0, 6'h01, 32'h0, rd);
    check(rd, BASE + 32'h1);
    report_and_stop();
  end
endmodule // testbench

`default_nettype wire
